// ---- hdl/register_ram_transfer_ops.sv ----
// Transfer unit: register and RAM moves of the 4-bit core
// Summary of operation
// - Accumulator-to-auxiliary copies acc[2:0] into aux, carry untouched.
// - Auxiliary-to-accumulator writes aux into acc[2:0] and zero in acc[3].
// - Bank-to-accumulator writes bank into acc[1:0] and clears acc[3:2].
// - File-to-accumulator copies the file pointer into acc unchanged.
// - Stack-to-accumulator writes stack_index into acc[2:0], zero in acc[3].
// - Pair load writes imm x to the file pointer and imm y to the column.
// - Pair loads that directly follow a pair load are skipped.
// - Bank load writes its 2-bit immediate into the bank pointer.
// - Column increment adds one and skips the next insn on wrap to zero.
// - Column decrement subtracts one and skips the next insn at fifteen.
// - RAM load copies the addressed nibble to acc then XORs file with imm.
// - RAM exchange swaps acc with the nibble then XORs file with imm.
// - Exchange-decrement also decrements column, skips on fifteen.
// - Exchange-increment also increments column, skips on zero.
// - RAM store writes acc to the nibble then XORs file with imm.
`timescale 1ns/1ps
module register_ram_transfer_ops (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Instruction slot
  input wire logic insn_valid,
  input wire logic [9:0] insn,
  // Core state owned elsewhere
  input wire logic [2:0] stack_index,
  input wire logic [3:0] addressed_ram_nibble,
  input wire logic carry_in,
  // Architectural state out
  output xfer_pkg::regs_t regs,
  output logic [10:0] ram_pointer_triple,
  output logic carry,
  // RAM write port and skip status
  output xfer_pkg::ram_req_t ram_req,
  output logic skip_pending,
  output logic slot_done
);

  xfer_pkg::dec_t dec;
  xfer_pkg::regs_t next_regs;
  xfer_pkg::ram_req_t next_ram_req;
  logic next_skip_pending;
  logic next_last_pair;
  logic last_pair;
  logic next_slot_done;
  logic next_carry;
  logic [10:0] next_pointer;
  logic [3:0] col_step;
  logic do_exec;

  // Decoder for the incoming word
  xfer_decode u_decode (
    .insn(insn),
    .dec(dec)
  );

  // Layout guard; a field past the word would alias opcode bits
  if (xfer_pkg::insn_w != $bits(insn) ||
      xfer_pkg::pair_x_lsb + 4 > xfer_pkg::insn_w) begin : g_field_check
    $error("instruction layout does not match the port width");
  end

  // Column step shared by the inc and dec forms
  function automatic logic [3:0] step_col(input logic [3:0] c,
                                          input logic up);
    step_col = up ? 4'(c + 4'h1) : 4'(c - 4'h1);
  endfunction : step_col

  // File pointer XOR shared by every RAM move
  function automatic logic [3:0] file_xor(input logic [3:0] f,
                                          input logic [3:0] j);
    file_xor = f ^ j;
  endfunction : file_xor

  // Wrap test: zero after a step up, fifteen after a step down
  function automatic logic wraps(input logic [3:0] c, input logic up);
    wraps = up ? (c == xfer_pkg::col_wrap_up)
               : (c == xfer_pkg::col_wrap_down);
  endfunction : wraps

  // Pair-load test for the chain flag and the chained skip
  function automatic logic is_pair(input xfer_pkg::op_t op);
    is_pair = (op == xfer_pkg::op_pair_load_immediate);
  endfunction : is_pair

  // Next-state computation for one instruction slot
  always_comb begin
    next_regs = regs;
    next_ram_req = '{wr: 1'b0, wdata: regs.acc};
    next_skip_pending = skip_pending;
    next_last_pair = last_pair;
    next_slot_done = 1'b0;
    col_step = regs.col;
    do_exec = 1'b0;
    if (insn_valid) begin
      next_slot_done = 1'b1;
      do_exec = !skip_pending && !(last_pair && is_pair(dec.op));
      next_last_pair = is_pair(dec.op);
      next_skip_pending = 1'b0;
      if (!do_exec) begin
        next_regs = regs;
      end else begin
        unique case (dec.op)
          xfer_pkg::op_acc_to_aux: next_regs.aux = regs.acc[2:0];
          xfer_pkg::op_aux_to_acc: next_regs.acc = {1'b0, regs.aux};
          xfer_pkg::op_bank_to_acc: next_regs.acc = {2'h0, regs.bank};
          xfer_pkg::op_file_to_acc: next_regs.acc = regs.file;
          xfer_pkg::op_stack_to_acc: next_regs.acc = {1'b0, stack_index};
          xfer_pkg::op_pair_load_immediate: begin
            next_regs.file = dec.imm_hi;
            next_regs.col = dec.imm_lo;
          end
          xfer_pkg::op_bank_load: next_regs.bank = dec.imm_lo[1:0];
          xfer_pkg::op_col_inc: begin
            col_step = step_col(regs.col, 1'b1);
            next_regs.col = col_step;
            next_skip_pending = wraps(col_step, 1'b1);
          end
          xfer_pkg::op_col_dec: begin
            col_step = step_col(regs.col, 1'b0);
            next_regs.col = col_step;
            next_skip_pending = wraps(col_step, 1'b0);
          end
          xfer_pkg::op_ram_load: begin
            next_regs.acc = addressed_ram_nibble;
            next_regs.file = file_xor(regs.file, dec.imm_lo);
          end
          xfer_pkg::op_ram_xchg: begin
            next_regs.acc = addressed_ram_nibble;
            next_ram_req.wr = 1'b1;
            next_regs.file = file_xor(regs.file, dec.imm_lo);
          end
          xfer_pkg::op_xchg_dec: begin
            next_regs.acc = addressed_ram_nibble;
            next_ram_req.wr = 1'b1;
            next_regs.file = file_xor(regs.file, dec.imm_lo);
            col_step = step_col(regs.col, 1'b0);
            next_regs.col = col_step;
            next_skip_pending = wraps(col_step, 1'b0);
          end
          xfer_pkg::op_xchg_inc: begin
            next_regs.acc = addressed_ram_nibble;
            next_ram_req.wr = 1'b1;
            next_regs.file = file_xor(regs.file, dec.imm_lo);
            col_step = step_col(regs.col, 1'b1);
            next_regs.col = col_step;
            next_skip_pending = wraps(col_step, 1'b1);
          end
          xfer_pkg::op_ram_store: begin
            next_ram_req.wr = 1'b1;
            next_regs.file = file_xor(regs.file, dec.imm_lo);
          end
          default: next_regs = regs; // Ops owned by other units
        endcase
      end
    end
  end

  // carry passes through
  // Transfers never compute a flag; the core's carry is only republished
  always_comb begin
    next_carry = carry;
    if (insn_valid) begin
      next_carry = carry_in;
    end
  end

  // Pointer triple rebuilt from the next pointer values
  always_comb begin
    next_pointer = {next_regs.bank, next_regs.aux, next_regs.file,
                    next_regs.col[3:2]};
  end

  // State registers; clk_en freezes everything
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      regs <= '{acc: xfer_pkg::acc_rst, aux: xfer_pkg::aux_rst,
                bank: xfer_pkg::bank_rst, file: xfer_pkg::file_rst,
                col: xfer_pkg::col_rst};
      ram_req <= '{wr: 1'b0, wdata: 4'h0};
      skip_pending <= 1'b0;
      last_pair <= 1'b0;
      slot_done <= 1'b0;
    end else if (clk_en) begin
      regs <= next_regs;
      ram_req <= next_ram_req;
      skip_pending <= next_skip_pending;
      last_pair <= next_last_pair;
      slot_done <= next_slot_done;
    end
  end

  // Carry copy; frozen with the rest of the state
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      carry <= 1'b0;
    end else if (clk_en) begin
      carry <= next_carry;
    end
  end

  // Pointer published in step with the registers it is built from
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ram_pointer_triple <= 11'h000;
    end else if (clk_en) begin
      ram_pointer_triple <= next_pointer;
    end
  end

endmodule : register_ram_transfer_ops

// ---- hdl/xfer_decode.sv ----
// Instruction decoder: maps a 10-bit word onto an operation class
`timescale 1ns/1ps
module xfer_decode (
  // Instruction in
  input wire logic [9:0] insn,
  // Decoded out
  output xfer_pkg::dec_t dec
);

  // Priority decode; unknown words are no-ops for this unit
  always_comb begin
    dec.imm_lo = insn[xfer_pkg::imm_lsb +: 4];
    dec.imm_hi = insn[xfer_pkg::pair_x_lsb +: 4];
    dec.op = xfer_pkg::op_none;
    if (insn[9:8] == xfer_pkg::pfx_pair) begin
      dec.op = xfer_pkg::op_pair_load_immediate;
    end else if (insn == xfer_pkg::opc_acc_to_aux) begin
      dec.op = xfer_pkg::op_acc_to_aux;
    end else if (insn == xfer_pkg::opc_aux_to_acc) begin
      dec.op = xfer_pkg::op_aux_to_acc;
    end else if (insn == xfer_pkg::opc_bank_to_acc) begin
      dec.op = xfer_pkg::op_bank_to_acc;
    end else if (insn == xfer_pkg::opc_file_to_acc) begin
      dec.op = xfer_pkg::op_file_to_acc;
    end else if (insn == xfer_pkg::opc_stack_to_acc) begin
      dec.op = xfer_pkg::op_stack_to_acc;
    end else if (insn == xfer_pkg::opc_col_inc) begin
      dec.op = xfer_pkg::op_col_inc;
    end else if (insn == xfer_pkg::opc_col_dec) begin
      dec.op = xfer_pkg::op_col_dec;
    end else if (insn[9:2] == xfer_pkg::pfx_bank) begin
      dec.op = xfer_pkg::op_bank_load;
    end else if (insn[9:4] == xfer_pkg::pfx_ram_load) begin
      dec.op = xfer_pkg::op_ram_load;
    end else if (insn[9:4] == xfer_pkg::pfx_ram_xchg) begin
      dec.op = xfer_pkg::op_ram_xchg;
    end else if (insn[9:4] == xfer_pkg::pfx_xchg_dec) begin
      dec.op = xfer_pkg::op_xchg_dec;
    end else if (insn[9:4] == xfer_pkg::pfx_xchg_inc) begin
      dec.op = xfer_pkg::op_xchg_inc;
    end else if (insn[9:4] == xfer_pkg::pfx_ram_store) begin
      dec.op = xfer_pkg::op_ram_store;
    end
  end

endmodule : xfer_decode

// ---- pkg/xfer_pkg.sv ----
// Package: opcodes, field layouts and reset values for the transfer unit
package xfer_pkg;

  // Instruction word width and field positions
  localparam int unsigned insn_w = 10;
  localparam int unsigned imm_lsb = 0;
  localparam int unsigned pair_x_lsb = 4;

  // Reset values of the pointer state
  localparam logic [3:0] acc_rst = 4'h0;
  localparam logic [2:0] aux_rst = 3'h0;
  localparam logic [1:0] bank_rst = 2'h0;
  localparam logic [3:0] file_rst = 4'h0;
  localparam logic [3:0] col_rst = 4'h0;

  // Column wrap values that cause a skip
  localparam logic [3:0] col_wrap_up = 4'h0;
  localparam logic [3:0] col_wrap_down = 4'hf;

  // Decoded operation classes
  typedef enum logic [3:0] {
    op_none = 4'h0,
    op_acc_to_aux = 4'h1,
    op_aux_to_acc = 4'h2,
    op_bank_to_acc = 4'h3,
    op_file_to_acc = 4'h4,
    op_stack_to_acc = 4'h5,
    op_pair_load_immediate = 4'h6,
    op_bank_load = 4'h7,
    op_col_inc = 4'h8,
    op_col_dec = 4'h9,
    op_ram_load = 4'ha,
    op_ram_xchg = 4'hb,
    op_xchg_dec = 4'hc,
    op_xchg_inc = 4'hd,
    op_ram_store = 4'he
  } op_t;

  // Fixed opcodes (full word match)
  localparam logic [9:0] opc_acc_to_aux = 10'h01f;
  localparam logic [9:0] opc_aux_to_acc = 10'h051;
  localparam logic [9:0] opc_bank_to_acc = 10'h053;
  localparam logic [9:0] opc_file_to_acc = 10'h052;
  localparam logic [9:0] opc_stack_to_acc = 10'h050;
  localparam logic [9:0] opc_col_inc = 10'h013;
  localparam logic [9:0] opc_col_dec = 10'h017;
  // Prefix opcodes: bits 9:4 (9:2 for bank load, 9:8 for pair load)
  localparam logic [1:0] pfx_pair = 2'h3;
  localparam logic [7:0] pfx_bank = 8'h12;
  localparam logic [5:0] pfx_ram_load = 6'h2c;
  localparam logic [5:0] pfx_ram_xchg = 6'h2d;
  localparam logic [5:0] pfx_xchg_dec = 6'h2f;
  localparam logic [5:0] pfx_xchg_inc = 6'h2e;
  localparam logic [5:0] pfx_ram_store = 6'h2b;

  // Decoded instruction carried to the execute stage
  typedef struct packed {
    op_t op;
    logic [3:0] imm_lo;
    logic [3:0] imm_hi;
  } dec_t;

  // Architectural state touched by this unit
  typedef struct packed {
    logic [3:0] acc;
    logic [2:0] aux;
    logic [1:0] bank;
    logic [3:0] file;
    logic [3:0] col;
  } regs_t;

  // RAM access request toward the data memory
  typedef struct packed {
    logic wr;
    logic [3:0] wdata;
  } ram_req_t;

endpackage : xfer_pkg

// ---- verification/register_ram_transfer_ops_tb.sv ----
// Self-checking bench for the transfer unit
`timescale 1ns/1ps
module register_ram_transfer_ops_tb;
  typedef struct packed {
    xfer_pkg::regs_t r;
    logic wr;
    logic [3:0] wd;
    logic sk;
    logic cy;
  } note_t;
  logic core_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, insn_valid = 1'b0;
  logic [9:0] insn = 10'h000;
  logic [2:0] stack_index = 3'h0;
  logic [3:0] addressed_ram_nibble = 4'h0;
  logic carry_in = 1'b0, carry, skip_pending, slot_done;
  logic [10:0] ram_pointer_triple;
  xfer_pkg::regs_t regs, m = '0;
  xfer_pkg::ram_req_t ram_req;
  note_t q[$];
  logic skip = 1'b0, prev_pair = 1'b0;
  int err_count = 0, samples_checked = 0, cyc = 0;
  logic [9:0] ops[15] = '{10'h01f, 10'h051, 10'h053, 10'h052, 10'h050,
    10'h300, 10'h048, 10'h013, 10'h017, 10'h2c0, 10'h2d0, 10'h2e0, 10'h2f0,
    10'h2b0, 10'h000};
  logic [9:0] msk[15] = '{10'h000, 10'h000, 10'h000, 10'h000, 10'h000,
    10'h0ff, 10'h003, 10'h000, 10'h000, 10'h00f, 10'h00f, 10'h00f, 10'h00f,
    10'h00f, 10'h000};
  register_ram_transfer_ops u_dut (.core_clk(core_clk), .rst_b(rst_b),
    .clk_en(clk_en), .insn_valid(insn_valid), .insn(insn),
    .stack_index(stack_index), .addressed_ram_nibble(addressed_ram_nibble),
    .carry_in(carry_in), .regs(regs), .ram_pointer_triple(ram_pointer_triple),
    .carry(carry), .ram_req(ram_req), .skip_pending(skip_pending),
    .slot_done(slot_done));
  // 100 MHz clock
  always #5 core_clk = ~core_clk;
  task automatic check(input string name, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic complete_run();
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  function automatic logic [9:0] pick();
    int i;
    i = $urandom % 15;
    return ops[i] | (10'($urandom) & msk[i]);
  endfunction : pick
  // Drive one slot at a falling edge and note the expected outcome
  task automatic run(input logic [9:0] w);
    note_t n;
    logic pair;
    logic [3:0] j;
    pair = (w[9:8] == 2'h3);
    j = w[3:0];
    {clk_en, insn_valid, insn} = {2'b11, w};
    stack_index = 3'($urandom);
    addressed_ram_nibble = 4'($urandom);
    carry_in = 1'($urandom);
    n.wr = 1'b0;
    n.wd = m.acc;
    n.cy = carry_in;
    if (skip || (pair && prev_pair)) skip = 1'b0;
    else if (w == 10'h01f) m.aux = m.acc[2:0];
    else if (w == 10'h051) m.acc = {1'b0, m.aux};
    else if (w == 10'h053) m.acc = {2'b00, m.bank};
    else if (w == 10'h052) m.acc = m.file;
    else if (w == 10'h050) m.acc = {1'b0, stack_index};
    else if (pair) {m.file, m.col} = w[7:0];
    else if (w[9:2] == 8'h12) m.bank = w[1:0];
    else if (w == 10'h013 || w == 10'h017) begin
      m.col = (w[2]) ? m.col - 4'h1 : m.col + 4'h1;
      skip = (m.col == (w[2] ? 4'hf : 4'h0));
    end
    else if (w[9:4] >= 6'h2b && w[9:4] <= 6'h2f) begin
      n.wr = (w[9:4] != 6'h2c);
      if (w[9:4] != 6'h2b) m.acc = addressed_ram_nibble;
      m.file = m.file ^ j;
      if (w[9:5] == 5'h17) begin
        m.col = (w[4]) ? m.col - 4'h1 : m.col + 4'h1;
        skip = (m.col == (w[4] ? 4'hf : 4'h0));
      end
    end
    prev_pair = pair;
    n.r = m;
    n.sk = skip;
    q.push_back(n);
    @(negedge core_clk);
  endtask : run
  // Result watcher: oldest note against each completed slot
  always @(posedge core_clk) begin
    #1;
    if (rst_b && slot_done === 1'b1) begin
      if (q.size() == 0) check("extra slot", 1, 0);
      else begin
        check("regs", regs, q[0].r);
        check("skip", skip_pending, q[0].sk);
        check("carry", carry, q[0].cy);
        check("pointer", ram_pointer_triple, {q[0].r.bank,
          q[0].r.aux, q[0].r.file, q[0].r.col[3:2]});
        check("wr", ram_req.wr, q[0].wr);
        if (q[0].wr) check("wdata", ram_req.wdata, q[0].wd);
        void'(q.pop_front());
      end
    end
  end
  // Hang guard, well above the expected run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(26542));
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst_b = 1'b1;
    // Chained pair loads, wrap skip, then a skipped move
    run(10'h30f);
    run(10'h355);
    run(10'h013);
    run(10'h051);
    repeat (4000) begin
      if ($urandom % 12 == 0) begin
        // Idle then a frozen slot that must be ignored
        insn_valid = 1'b0;
        @(negedge core_clk);
        {clk_en, insn_valid, insn} = {2'b01, pick()};
        @(negedge core_clk);
      end
      run(pick());
    end
    insn_valid = 1'b0;
    repeat (3) @(negedge core_clk);
    check("pending notes", q.size(), 0);
    complete_run();
  end
endmodule : register_ram_transfer_ops_tb

// ---- verification/xfer_checker_assertions.sv ----
// Port-level assertions for the register and RAM transfer unit
`timescale 1ns/1ps
module xfer_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Inputs watched
  input wire logic clk_en,
  input wire logic insn_valid,
  input wire logic [9:0] insn,
  input wire logic [2:0] stack_index,
  input wire logic [3:0] addressed_ram_nibble,
  input wire logic carry_in,
  // Outputs watched
  input wire xfer_pkg::regs_t regs,
  input wire logic [10:0] ram_pointer_triple,
  input wire logic carry,
  input wire xfer_pkg::ram_req_t ram_req,
  input wire logic skip_pending,
  input wire logic slot_done
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Slot that executes; only valid for words that are not pair loads
  logic go;
  assign go = clk_en && insn_valid && !skip_pending;
  a_done_follows: assert property (clk_en && insn_valid |=> slot_done)
    else $error("slot_done missing after a slot");
  a_skip_clears: assert property (clk_en && insn_valid && skip_pending
    |=> !skip_pending && $stable(regs)) else $error("skipped slot acted");
  a_inc_wrap: assert property (go && insn == 10'h013
    && regs.col == 4'hf |=> skip_pending && regs.col == 4'h0)
    else $error("inc wrap wrong");
  a_dec_wrap: assert property (go && insn == 10'h017
    && regs.col == 4'h0 |=> skip_pending && regs.col == 4'hf)
    else $error("dec wrap wrong");
  a_aux_copy: assert property (go && insn == 10'h01f
    |=> regs.aux == $past(regs.acc[2:0]) && carry == $past(carry_in))
    else $error("aux");
  a_aux_read: assert property (go && insn == 10'h051
    |=> regs.acc == {1'b0, $past(regs.aux)}) else $error("aux read");
  a_stack_read: assert property (go && insn == 10'h050
    |=> regs.acc == {1'b0, $past(stack_index)}) else $error("stack");
  a_bank_load: assert property (go && insn[9:2] == 8'h12
    |=> regs.bank == $past(insn[1:0])) else $error("bank load");
  a_ram_load: assert property (go && insn[9:4] == 6'h2c
    |=> regs.acc == $past(addressed_ram_nibble)
    && regs.file == $past(regs.file ^ insn[3:0])) else $error("ram load");
  a_store_pulse: assert property (go && insn[9:4] == 6'h2b
    |=> ram_req.wr && ram_req.wdata == $past(regs.acc)) else $error("store");
  a_xchg_swap: assert property (go && insn[9:4] == 6'h2d
    |=> regs.acc == $past(addressed_ram_nibble) && ram_req.wr
    && ram_req.wdata == $past(regs.acc)) else $error("exchange");
  a_pair_chain: assert property ((clk_en && insn_valid
    && insn[9:8] == 2'h3) ##1 (clk_en && insn_valid && insn[9:8] == 2'h3)
    |=> $stable(regs) && !skip_pending) else $error("chained pair acted");
  // Main scenarios reached
  c_inc_wrap: cover property (go && insn == 10'h013 && regs.col == 4'hf);
  c_pair_chain: cover property ((insn_valid && insn[9:8] == 2'h3)
    ##1 (insn_valid && insn[9:8] == 2'h3));
  c_pair_skip: cover property (insn_valid && skip_pending && insn[9:8] == 2'h3);
  c_ram_write: cover property (ram_req.wr);
endmodule : xfer_checker
bind register_ram_transfer_ops xfer_checker u_chk (.core_clk(core_clk),
  .rst_b(rst_b), .clk_en(clk_en), .insn_valid(insn_valid), .insn(insn),
  .stack_index(stack_index), .addressed_ram_nibble(addressed_ram_nibble),
  .carry_in(carry_in), .regs(regs), .ram_pointer_triple(ram_pointer_triple),
  .carry(carry), .ram_req(ram_req), .skip_pending(skip_pending),
  .slot_done(slot_done));
